// ==== dv/pals_host.sv ====
// Purpose: host software model on the register port
// Assumes: one byte per access, interrupt clear as a pulse
// Notes: released write data shows the inverted byte
`timescale 1ns/1ps
module pals_host (
	input wire logic sys_clk,
	input wire logic [7:0] regRdData,
	output logic [7:0] regAddr,
	output logic regWrEn,
	output logic [7:0] regWrData,
	output logic irqClear
);
	import pals_pkg::*;
	// ****************
	// Accesses
	// ****************
	// Idle port at time zero
	initial begin
		regAddr = 8'h00;
		regWrEn = 1'b0;
		regWrData = 8'h00;
		irqClear = 1'b0;
	end
	// Write one byte; spare config bits always sent low
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		regAddr = a;
		regWrData = (a == PALS_ADDR_WSCALE) ? (d & PALS_WSCALE_MASK) : d;
		regWrEn = 1'b1;
		@(posedge sys_clk);
		#1;
		regWrEn = 1'b0;
		regWrData = ~regWrData;
	endtask
	// Read data lands one edge after the address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		#1;
		regAddr = a;
		@(posedge sys_clk);
		#1;
		d = regRdData;
	endtask
	// One-cycle clear of both flags
	task automatic clr();
		@(posedge sys_clk);
		#1;
		irqClear = 1'b1;
		@(posedge sys_clk);
		#1;
		irqClear = 1'b0;
	endtask
endmodule

// ==== dv/prox_als_interrupt_persistence_tb.sv ====
// Purpose: self-checking bench for the persistence filter block
// Assumes: time unit shortened to 4 clocks
// Notes: out-of-range results come from a fixed seed
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin \
	n_errors++; $display("[FAIL] %s exp %0h got %0h", nm, e, s); end end
module prox_als_interrupt_persistence_tb;
	import pals_pkg::*;
	localparam int U = 4;
	logic sys_clk, rst_n, proxFunctionOn, lightFunctionOn, waitEnable;
	logic proxIrqMask, lightIrqMask, irqClear, regWrEn, ledPulse, irqOut;
	logic [7:0] regAddr, regWrData, regRdData, d;
	logic [15:0] chan0Result, lightLowThresh, lightHighThresh;
	logic [15:0] proxResult, proxLowThresh, proxHighThresh;
	logic [1:0] seqState, prevS, afterLight;
	logic prevL;
	int n_errors, checks_done, seed, lEnds, pEnds, rises, r0, plast;
	int gap, lastRise, cyc, wcnt, wlen, pd, np;
	logic [7:0] adr [6] = '{8'h01, 8'h03, 8'h0c, 8'h0d, 8'h0e, 8'h13};
	logic [15:0] walk [5] = '{16'd300, 16'd200, 16'd50, 16'd100, 16'd300};

	pals_core #(.UNIT_CYCLES(U)) DUT (.sys_clk, .rst_n, .regAddr,
		.regWrEn, .regWrData, .regRdData, .proxFunctionOn,
		.lightFunctionOn, .waitEnable, .proxIrqMask, .lightIrqMask,
		.irqClear, .chan0Result, .lightLowThresh, .lightHighThresh,
		.proxResult, .proxLowThresh, .proxHighThresh, .ledPulse,
		.irqOut, .seqState);
	pals_host HOST (.sys_clk, .regRdData, .regAddr, .regWrEn,
		.regWrData, .irqClear);

	// ****************
	// Expectations
	// ****************
	function automatic int need(input int x);
		return x == 0 ? 1 : (x < 4 ? x : 5 * x - 15);
	endfunction
	function automatic int waitCyc(input bit x);
		return (256 - 8'hff) * U * (x ? PALS_LONG_FACTOR : 1);
	endfunction

	// ****************
	// Monitors and helpers
	// ****************
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Event counts sampled from pre-edge values
	always @(posedge sys_clk) begin
		cyc++;
		if (prevS == PALS_LIGHT && seqState != PALS_LIGHT) begin
			lEnds++;
			afterLight = seqState;
		end
		if (seqState == PALS_PROX && prevS != PALS_PROX)
			r0 = rises;
		if (prevS == PALS_PROX && seqState != PALS_PROX) begin
			pEnds++;
			plast = rises - r0;
		end
		if (ledPulse && !prevL) begin
			gap = cyc - lastRise;
			lastRise = cyc;
			rises++;
		end
		if (seqState == PALS_WAIT)
			wcnt++;
		else if (prevS == PALS_WAIT) begin
			wlen = wcnt;
			wcnt = 0;
		end
		prevS = seqState;
		prevL = ledPulse;
	end
	task automatic waitEnd(input bit px);
		int c;
		c = px ? pEnds : lEnds;
		for (int i = 0; i < 4000 && c == (px ? pEnds : lEnds); i++) begin
			@(posedge sys_clk);
			#1;
		end
	endtask
	task automatic waitIrq();
		for (int i = 0; i < 10000 && irqOut !== 1'b1; i++) begin
			@(posedge sys_clk);
			#1;
		end
	endtask
	// In-range result clears any partial run before counting
	task automatic settle(input bit px);
		if (px)
			proxResult = 16'd150;
		else
			chan0Result = 16'd150;
		waitEnd(px);
		HOST.clr();
		// Registered interrupt lags the clear by one edge
		repeat (2) @(posedge sys_clk);
		#1;
		lEnds = 0;
		pEnds = 0;
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Hang guard well past the expected run
	initial begin
		#2000000;
		n_errors++;
		stop_test();
	end

	// ****************
	// Tests
	// ****************
	initial begin
		seed = 32'h4afe;
		{proxFunctionOn, lightFunctionOn, waitEnable} = 3'b000;
		{proxIrqMask, lightIrqMask} = 2'b00;
		{lightLowThresh, proxLowThresh} = {16'd100, 16'd100};
		{lightHighThresh, proxHighThresh} = {16'd200, 16'd200};
		{chan0Result, proxResult} = {16'd150, 16'd150};
		rst_n = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		foreach (adr[i]) begin
			HOST.rd(adr[i], d);
			`CHK("reset value", 8'h00, d)
		end
		HOST.wr(PALS_ADDR_PULSE, 8'ha5);
		HOST.rd(PALS_ADDR_PULSE, d);
		`CHK("pulse reg", 8'ha5, d)
		HOST.wr(PALS_ADDR_WSCALE, 8'hff);
		HOST.rd(PALS_ADDR_WSCALE, d);
		`CHK("wscale reg", 8'h02, d)
		HOST.wr(8'h20, 8'h77);
		HOST.rd(8'h20, d);
		`CHK("unmapped", 8'h00, d)
		$display("test registers done");
		HOST.wr(PALS_ADDR_WSCALE, 8'h00);
		HOST.wr(PALS_ADDR_INTEG, 8'hfe);
		HOST.wr(PALS_ADDR_WAIT, 8'hff);
		lightFunctionOn = 1'b1;
		lightIrqMask = 1'b1;
		for (int x = 0; x < 16; x++) begin
			HOST.wr(PALS_ADDR_FILTER, 8'(x));
			settle(0);
			if (x != 0)
				chan0Result = ($random(seed) & 1) ? 16'd260 : 16'd7;
			waitIrq();
			`CHK("light runs", need(x), lEnds)
		end
		lightIrqMask = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		`CHK("masked irq", 1'b0, irqOut)
		HOST.rd(PALS_ADDR_STATUS, d);
		`CHK("light flag", 1'b1, d[PALS_STAT_LIGHT_BIT])
		lightIrqMask = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		`CHK("held irq", 1'b1, irqOut)
		HOST.clr();
		repeat (2) @(posedge sys_clk);
		#1;
		`CHK("cleared irq", 1'b0, irqOut)
		$display("test light filter done");
		{lightFunctionOn, lightIrqMask} = 2'b00;
		{proxFunctionOn, proxIrqMask} = 2'b11;
		for (int k = 0; k < 4; k++) begin
			pd = k == 0 ? 0 : 1 + ($unsigned($random(seed)) % 3);
			np = 2 + ($unsigned($random(seed)) % 2);
			HOST.wr(PALS_ADDR_FILTER, 8'(pd << 4));
			HOST.wr(PALS_ADDR_PULSE, 8'(np));
			settle(1);
			if (pd != 0)
				proxResult = 16'd300 + 16'($random(seed) & 16'hfff);
			waitIrq();
			`CHK("prox runs", pd == 0 ? 1 : pd, pEnds)
			`CHK("pulses", np, plast)
			`CHK("pulse gap", PALS_PULSE_CYCLES, gap)
			`CHK("after light", PALS_PROX, afterLight)
		end
		HOST.wr(PALS_ADDR_PULSE, 8'h01);
		HOST.wr(PALS_ADDR_FILTER, 8'h20);
		settle(1);
		foreach (walk[i]) begin
			proxResult = walk[i];
			waitEnd(1);
		end
		repeat (3) @(posedge sys_clk);
		#1;
		`CHK("broken run", 1'b0, irqOut)
		waitEnd(1);
		repeat (2) @(posedge sys_clk);
		#1;
		`CHK("second out", 1'b1, irqOut)
		$display("test prox filter done");
		waitEnable = 1'b1;
		for (int w = 0; w < 2; w++) begin
			HOST.wr(PALS_ADDR_WSCALE, w ? 8'h02 : 8'h00);
			waitEnd(1);
			waitEnd(1);
			`CHK("wait span", waitCyc(w), wlen)
		end
		// Light-only cycles go straight from light to wait
		HOST.wr(PALS_ADDR_WSCALE, 8'h00);
		{proxFunctionOn, lightFunctionOn} = 2'b01;
		waitEnd(0);
		waitEnd(0);
		`CHK("light wait", waitCyc(0), wlen)
		$display("test wait done");
		stop_test();
	end
endmodule

// ==== rtl/pals_core.sv ====
// Purpose: interrupt persistence filters, wait scaling and LED pulse train
// Assumes: register port driven by the serial front end on sys_clk
// Notes: analog results arrive on sys_clk, valid at end of each cycle
//
// What this block does
// - Separate proximity and light persistence filters, each own field and count.
// - Light threshold check uses channel zero result only.
// - Proximity depth bits 7:4 zero interrupts at every proximity cycle end.
// - Proximity depth 1..15 needs that many consecutive out-of-range results.
// - Light depth bits 3:0 zero interrupts after every integration cycle with light on.
// - Light depth 1,2,3 needs 1,2,3 consecutive out-of-range results.
// - Light depth 4..15 needs five times depth minus fifteen results.
// - Wait-times-twelve bit 1 stretches every wait period twelvefold.
// - Each proximity cycle emits exactly the programmed count of LED pulses.
// - LED pulses repeat every 16 us, a 62.5 kHz rate.
// - With proximity on, a proximity cycle follows every light cycle.
// - Integration setting times proximity spacing even with light off.
// - Out of range means below low or above high threshold.
// - Wait timer counts 2.72 ms units before the long multiplier.
// - Each passed interrupt reaches the output only under its mask.

`timescale 1ns/1ps

module pals_core #(
	parameter int UNIT_CYCLES = pals_pkg::PALS_UNIT_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	input wire logic proxFunctionOn,
	input wire logic lightFunctionOn,
	input wire logic waitEnable,
	input wire logic proxIrqMask,
	input wire logic lightIrqMask,
	input wire logic irqClear,
	input wire logic [15:0] chan0Result,
	input wire logic [15:0] lightLowThresh,
	input wire logic [15:0] lightHighThresh,
	input wire logic [15:0] proxResult,
	input wire logic [15:0] proxLowThresh,
	input wire logic [15:0] proxHighThresh,
	output logic ledPulse,
	output logic irqOut,
	output logic [1:0] seqState
);
	import pals_pkg::*;

	localparam int PULSE_HALF = PALS_PULSE_CYCLES / 2;

	// ********************************************
	// Registers and state
	// ********************************************
	logic [7:0] integSetting_r, integSetting_nxt;
	logic [7:0] waitSetting_r, waitSetting_nxt;
	logic [7:0] filterCfg_r, filterCfg_nxt;
	logic [7:0] waitScale_r, waitScale_nxt;
	logic [7:0] pulseTotal_r, pulseTotal_nxt;
	logic [7:0] rdData_r, rdData_nxt;
	pals_state_t state_r, state_nxt;
	logic [16:0] unitCnt_r, unitCnt_nxt;
	logic [11:0] unitsLeft_r, unitsLeft_nxt;
	logic [9:0] pulseDiv_r, pulseDiv_nxt;
	logic [7:0] pulsesLeft_r, pulsesLeft_nxt;
	logic led_r, led_nxt;
	logic [9:0] ledAge_r, ledAge_nxt;
	logic proxDone, lightDone, unitTick;
	logic [3:0] proxCnt_r, proxCnt_nxt;
	logic [5:0] lightCnt_r, lightCnt_nxt;
	logic proxFlag_r, proxFlag_nxt;
	logic lightFlag_r, lightFlag_nxt;
	logic irq_r, irq_nxt;
	logic [3:0] proxDepth, lightDepth;
	logic [5:0] lightNeed;
	logic proxOut, lightOut;
	logic [11:0] waitUnits;

	assign proxDepth = filterCfg_r[PALS_PROX_DEPTH_LSB +: 4];
	assign lightDepth = filterCfg_r[PALS_LIGHT_DEPTH_LSB +: 4];

	// Light depth to run length: table is linear above three
	assign lightNeed = (lightDepth <= 4'h3) ? {2'b00, lightDepth} :
		6'(6'(lightDepth) * 6'h05 - 6'h0f);

	// Window test; channel one never enters the light path
	assign proxOut = (proxResult < proxLowThresh) ||
		(proxResult > proxHighThresh);
	assign lightOut = (chan0Result < lightLowThresh) ||
		(chan0Result > lightHighThresh);

	// Wait length in 2.72 ms units, stretched by twelve when selected
	assign waitUnits = waitScale_r[PALS_WAIT_X12_BIT] ?
		12'(12'(9'h100 - 9'(waitSetting_r)) * 12'(PALS_LONG_FACTOR)) :
		12'(9'h100 - 9'(waitSetting_r));

	// ********************************************
	// Register port
	// ********************************************
	// Unused configuration bits are dropped; host should write zero anyway
	always_comb begin
		integSetting_nxt = integSetting_r;
		waitSetting_nxt = waitSetting_r;
		filterCfg_nxt = filterCfg_r;
		waitScale_nxt = waitScale_r;
		pulseTotal_nxt = pulseTotal_r;
		if (regWrEn) begin
			case (regAddr)
				PALS_ADDR_INTEG: integSetting_nxt = regWrData;
				PALS_ADDR_WAIT: waitSetting_nxt = regWrData;
				PALS_ADDR_FILTER: filterCfg_nxt = regWrData;
				PALS_ADDR_WSCALE: waitScale_nxt = regWrData & PALS_WSCALE_MASK;
				PALS_ADDR_PULSE: pulseTotal_nxt = regWrData;
				default: ;
			endcase
		end
		case (regAddr)
			PALS_ADDR_INTEG: rdData_nxt = integSetting_r;
			PALS_ADDR_WAIT: rdData_nxt = waitSetting_r;
			PALS_ADDR_FILTER: rdData_nxt = filterCfg_r;
			PALS_ADDR_WSCALE: rdData_nxt = waitScale_r;
			PALS_ADDR_PULSE: rdData_nxt = pulseTotal_r;
			PALS_ADDR_STATUS: begin
				rdData_nxt = 8'h00;
				rdData_nxt[PALS_STAT_PROX_BIT] = proxFlag_r;
				rdData_nxt[PALS_STAT_LIGHT_BIT] = lightFlag_r;
			end
			default: rdData_nxt = 8'h00;
		endcase
	end

	// ********************************************
	// Cycle sequencer and LED pulse train
	// ********************************************
	assign unitTick = (unitCnt_r == 17'(UNIT_CYCLES - 1));

	// Integration timing runs whenever either function is on
	always_comb begin
		state_nxt = state_r;
		unitCnt_nxt = unitTick ? 17'h00000 : 17'(unitCnt_r + 17'h00001);
		unitsLeft_nxt = unitsLeft_r;
		pulseDiv_nxt = pulseDiv_r;
		pulsesLeft_nxt = pulsesLeft_r;
		led_nxt = 1'b0;
		ledAge_nxt = (state_r != PALS_PROX) ? 10'h3ff :
			10'(ledAge_r + 10'h001); // Check helper, parked outside prox
		proxDone = 1'b0;
		lightDone = 1'b0;
		case (state_r)
			PALS_IDLE: begin
				unitCnt_nxt = 17'h00000;
				if (proxFunctionOn || lightFunctionOn) begin
					state_nxt = PALS_LIGHT;
					unitsLeft_nxt = 12'(9'h100 - 9'(integSetting_r));
				end
			end
			PALS_LIGHT: begin
				if (unitTick) begin
					unitsLeft_nxt = 12'(unitsLeft_r - 12'h001);
					if (unitsLeft_r == 12'h001) begin
						lightDone = lightFunctionOn;
						pulseDiv_nxt = 10'h000;
						pulsesLeft_nxt = pulseTotal_r;
						if (proxFunctionOn) begin
							state_nxt = PALS_PROX;
						end else if (waitEnable) begin
							state_nxt = PALS_WAIT;
							unitsLeft_nxt = waitUnits;
						end else begin
							state_nxt = PALS_IDLE;
						end
					end
				end
			end
			PALS_PROX: begin
				// Pulse is high for the first half of each 16 us slot
				if (pulsesLeft_r == 8'h00) begin
					proxDone = 1'b1;
					unitCnt_nxt = 17'h00000;
					state_nxt = waitEnable ? PALS_WAIT : PALS_IDLE;
					unitsLeft_nxt = waitUnits;
				end else begin
					led_nxt = (pulseDiv_r < 10'(PULSE_HALF));
					if (led_nxt && !led_r) begin
						ledAge_nxt = 10'h000;
					end
					if (pulseDiv_r == 10'(PALS_PULSE_CYCLES - 1)) begin
						pulseDiv_nxt = 10'h000;
						pulsesLeft_nxt = 8'(pulsesLeft_r - 8'h01);
					end else begin
						pulseDiv_nxt = 10'(pulseDiv_r + 10'h001);
					end
				end
			end
			PALS_WAIT: begin
				if (unitTick) begin
					unitsLeft_nxt = 12'(unitsLeft_r - 12'h001);
					if (unitsLeft_r == 12'h001) begin
						state_nxt = PALS_IDLE;
					end
				end
			end
			default: state_nxt = PALS_IDLE;
		endcase
	end

	// ********************************************
	// Persistence filters and interrupt
	// ********************************************
	// Set beats a clear landing in the same cycle so no event is lost
	always_comb begin
		proxCnt_nxt = proxCnt_r;
		lightCnt_nxt = lightCnt_r;
		proxFlag_nxt = irqClear ? 1'b0 : proxFlag_r;
		lightFlag_nxt = irqClear ? 1'b0 : lightFlag_r;
		if (proxDone) begin
			if (proxDepth == 4'h0) begin
				proxFlag_nxt = 1'b1;
				proxCnt_nxt = 4'h0;
			end else if (!proxOut) begin
				proxCnt_nxt = 4'h0;
			end else if (4'(proxCnt_r + 4'h1) >= proxDepth) begin
				proxFlag_nxt = 1'b1;
				proxCnt_nxt = 4'h0;
			end else begin
				proxCnt_nxt = 4'(proxCnt_r + 4'h1);
			end
		end
		if (lightDone) begin
			if (lightDepth == 4'h0) begin
				lightFlag_nxt = 1'b1;
				lightCnt_nxt = 6'h00;
			end else if (!lightOut) begin
				lightCnt_nxt = 6'h00;
			end else if (6'(lightCnt_r + 6'h01) >= lightNeed) begin
				lightFlag_nxt = 1'b1;
				lightCnt_nxt = 6'h00;
			end else begin
				lightCnt_nxt = 6'(lightCnt_r + 6'h01);
			end
		end
		irq_nxt = (proxFlag_r && proxIrqMask) ||
			(lightFlag_r && lightIrqMask);
	end

	// All state registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			integSetting_r <= PALS_REG_RESET;
			waitSetting_r <= PALS_REG_RESET;
			filterCfg_r <= PALS_REG_RESET;
			waitScale_r <= PALS_REG_RESET;
			pulseTotal_r <= PALS_REG_RESET;
			rdData_r <= 8'h00;
			state_r <= PALS_IDLE;
			unitCnt_r <= 17'h00000;
			unitsLeft_r <= 12'h000;
			pulseDiv_r <= 10'h000;
			pulsesLeft_r <= 8'h00;
			led_r <= 1'b0;
			ledAge_r <= 10'h3ff;
			proxCnt_r <= 4'h0;
			lightCnt_r <= 6'h00;
			proxFlag_r <= 1'b0;
			lightFlag_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			integSetting_r <= integSetting_nxt;
			waitSetting_r <= waitSetting_nxt;
			filterCfg_r <= filterCfg_nxt;
			waitScale_r <= waitScale_nxt;
			pulseTotal_r <= pulseTotal_nxt;
			rdData_r <= rdData_nxt;
			state_r <= state_nxt;
			unitCnt_r <= unitCnt_nxt;
			unitsLeft_r <= unitsLeft_nxt;
			pulseDiv_r <= pulseDiv_nxt;
			pulsesLeft_r <= pulsesLeft_nxt;
			led_r <= led_nxt;
			ledAge_r <= ledAge_nxt;
			proxCnt_r <= proxCnt_nxt;
			lightCnt_r <= lightCnt_nxt;
			proxFlag_r <= proxFlag_nxt;
			lightFlag_r <= lightFlag_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign regRdData = rdData_r;
	assign ledPulse = led_r;
	assign irqOut = irq_r;
	assign seqState = state_r;

	// ********************************************
	// Checks
	// ********************************************
	prox_every_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		proxDone && proxDepth == 4'h0 |=> proxFlag_r)
		else $error("prox depth zero did not flag");
	prox_run_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(proxFlag_r) && proxDepth != 4'h0 |->
		$past(proxOut) && $past(proxCnt_r) == proxDepth - 4'h1)
		else $error("prox flag without full run");
	light_every_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		lightDone && lightDepth == 4'h0 |=> lightFlag_r)
		else $error("light depth zero did not flag");
	light_run_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(lightFlag_r) && lightDepth != 4'h0 |->
		$past(lightCnt_r) == 6'($past(lightNeed) - 6'h01))
		else $error("light flag without full run");
	light_need_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		lightDepth == 4'hf |-> lightNeed == 6'd60)
		else $error("light depth fifteen must need sixty");
	in_window_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		proxDone && !proxOut |=> proxCnt_r == 4'h0)
		else $error("in-window result kept the count");
	flag_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		proxFlag_r && !irqClear |=> proxFlag_r)
		else $error("prox flag dropped without clear");
	irq_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!proxIrqMask && !lightIrqMask |=> !irqOut)
		else $error("masked interrupt reached output");
	led_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(ledPulse) |-> $past(ledAge_r) == 10'(PULSE_HALF - 1))
		else $error("LED high time wrong");
	led_period_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(ledPulse) |-> $past(ledAge_r) == 10'h3ff ||
		$past(ledAge_r) == 10'(PALS_PULSE_CYCLES - 1))
		else $error("LED pulse period wrong");
	prox_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_r == PALS_LIGHT && state_nxt != PALS_LIGHT && proxFunctionOn
		|=> state_r == PALS_PROX)
		else $error("prox cycle did not follow light cycle");

endmodule

// ==== rtl/pals_pkg.sv ====
// Purpose: constants for the light and proximity interrupt filter block
// Assumes: 40 MHz system clock, 8-bit register port
// Notes: register reset values are chosen as zero

package pals_pkg;

	// ********************************************
	// Register map
	// ********************************************
	localparam logic [7:0] PALS_ADDR_INTEG = 8'h01;
	localparam logic [7:0] PALS_ADDR_WAIT = 8'h03;
	localparam logic [7:0] PALS_ADDR_FILTER = 8'h0c;
	localparam logic [7:0] PALS_ADDR_WSCALE = 8'h0d;
	localparam logic [7:0] PALS_ADDR_PULSE = 8'h0e;
	localparam logic [7:0] PALS_ADDR_STATUS = 8'h13;

	// ********************************************
	// Fields and reset values
	// ********************************************
	localparam int PALS_PROX_DEPTH_LSB = 4;
	localparam int PALS_LIGHT_DEPTH_LSB = 0;
	localparam int PALS_WAIT_X12_BIT = 1;
	localparam int PALS_STAT_PROX_BIT = 5;
	localparam int PALS_STAT_LIGHT_BIT = 4;
	localparam logic [7:0] PALS_REG_RESET = 8'h00;
	localparam logic [7:0] PALS_WSCALE_MASK = 8'h02;

	// ********************************************
	// Timing
	// ********************************************
	localparam int PALS_CLK_KHZ = 40000;
	localparam int PALS_UNIT_US = 2720;
	localparam int PALS_UNIT_CYCLES = PALS_UNIT_US * PALS_CLK_KHZ / 1000;
	localparam int PALS_PULSE_PERIOD_US = 16;
	localparam int PALS_PULSE_CYCLES =
		PALS_PULSE_PERIOD_US * PALS_CLK_KHZ / 1000;
	localparam int PALS_LONG_FACTOR = 12;

	// Sequencer states
	typedef enum logic [1:0] {
		PALS_IDLE = 2'b00,
		PALS_LIGHT = 2'b01,
		PALS_PROX = 2'b10,
		PALS_WAIT = 2'b11
	} pals_state_t;

endpackage
